// file: sysclk_div_map.svh
// Register map, field positions and reset values for the clock dividers
`ifndef SYSCLK_DIV_MAP_SVH
`define SYSCLK_DIV_MAP_SVH

// Byte addresses on the register bus
`define CMD_OFS 32'h029A_0138
`define STAT_OFS 32'h029A_013C
`define CHG_OFS 32'h029A_0144
`define MEMIF_DIV_OFS 32'h029A_0160
`define SECOND_DIV_OFS 32'h029A_0164

// Field positions
`define DIV_ON_BIT 15
`define RATIO_MSB 4
`define CODE_MSB 2
`define GO_BIT 0
`define BUSY_BIT 0
`define MEMIF_FLAG_BIT 3
`define SECOND_FLAG_BIT 4

// Reset values
`define RATIO_RST 5'h03
`define ON_RST 1'b1
`define WORD_ZERO 32'h0000_0000

// Longest wait for a finished change, in clock cycles
`define GO_MAX_CYCLES 24

`endif

// file: sysclk_div_pkg.sv
// Types shared by the clock divider block
package sysclk_div_pkg;

   // Settings of one divider as software programs them
   typedef struct packed {
      logic on;
      logic [4:0] ratio;
   } divider_cfg_type;

   // Flags for the two dividers, second divider high
   typedef struct packed {
      logic second;
      logic memif;
   } divider_pair_type;

   // Sequence of one ratio change operation
   typedef enum logic [1:0] {
      st_idle,
      st_wait,
      st_apply,
      st_done
   } go_state_type;

endpackage

// file: clock_tick_divider.sv
// One programmable divider producing a one-cycle tick every N clocks
`timescale 1ns/1ns
`default_nettype none

module clock_tick_divider (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic on,
   input wire logic [4:0] divisor,
   input wire logic restart,
   // Results
   output logic tick_r,
   output logic period_end
);

   logic [4:0] cnt_r; // Position inside the current period
   logic [4:0] last_w; // Final count of a period
   logic [4:0] cnt_nxt;

   assign last_w = divisor - 5'h01;
   assign period_end = on && (cnt_r == last_w);
   assign cnt_nxt = period_end ? 5'h00 : cnt_r + 5'h01;

   // Counter and tick; restart opens a fresh period for alignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 5'h00;
         tick_r <= 1'b0;
      end else if (restart || !on) begin
         cnt_r <= 5'h00;
         tick_r <= on;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= period_end;
      end
   end

   // A stopped divider stays silent
   a_off_silent: assert property (
      @(posedge pclk) disable iff (!presetn) !on |=> !tick_r)
      else $error("tick from disabled divider");

   // Ticks of a divider above one never come back to back unless a restart comes between them
   a_tick_spacing: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick_r && on && !restart && divisor > 5'h01) |=> !tick_r)
      else $error("ticks too close");

endmodule

`default_nettype wire

// file: sysclk_divider_go_control.sv
// APB register block, two system clock dividers and the ratio change engine
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "sysclk_div_map.svh"

module sysclk_divider_go_control
   import sysclk_div_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   // Divided clock ticks
   output logic memif_system_clock,
   output logic second_system_clock
);

   // Checks in this module run on the bus clock and sleep in reset
   default clocking chk_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Programmed settings and ratios in force
   divider_cfg_type memif_cfg_r; // Memif divider register
   divider_cfg_type second_cfg_r; // Second divider register
   logic [4:0] memif_act_r; // Ratio the memif divider runs at
   logic [4:0] second_act_r; // Ratio the second divider runs at
   logic cmd_r; // Sticky trigger bit
   logic busy_r; // Change in progress
   divider_pair_type chg_r; // Divider changed flags
   divider_pair_type chg_nxt;
   divider_pair_type applied_r; // Flags taken by the running change
   go_state_type state_r;
   go_state_type state_nxt;

   // Bus decode
   logic setup_w; // Access phase, answer not given yet
   logic acc_w; // Completing edge of a transfer
   logic wr_w;
   logic hit_cmd;
   logic hit_stat;
   logic hit_chg;
   logic hit_memif;
   logic hit_second;
   logic hit_any;
   logic [31:0] rdata_w;

   assign setup_w = psel && penable && !pready_r;
   assign acc_w = psel && penable && pready_r;
   assign wr_w = acc_w && pwrite;
   assign hit_cmd = (paddr == `CMD_OFS);
   assign hit_stat = (paddr == `STAT_OFS);
   assign hit_chg = (paddr == `CHG_OFS);
   assign hit_memif = (paddr == `MEMIF_DIV_OFS);
   assign hit_second = (paddr == `SECOND_DIV_OFS);
   assign hit_any = hit_cmd || hit_stat || hit_chg || hit_memif
      || hit_second;

   // Register write strobes
   logic wr_cmd;
   logic wr_memif;
   logic wr_second;
   logic go_start; // Launch request from software
   logic set_memif; // Ratio written differs from the held one
   logic set_second;

   assign wr_cmd = wr_w && hit_cmd;
   assign wr_memif = wr_w && hit_memif;
   assign wr_second = wr_w && hit_second;
   // A write of 1 launches even with the bit already set
   assign go_start = wr_cmd && pwdata[`GO_BIT];
   assign set_memif = wr_memif &&
      (pwdata[`RATIO_MSB:0] != memif_cfg_r.ratio);
   assign set_second = wr_second &&
      (pwdata[`RATIO_MSB:0] != second_cfg_r.ratio);

   // Read mux; fields outside the defined bits read zero
   logic [31:0] memif_rd_w;
   logic [31:0] second_rd_w;
   logic [31:0] chg_rd_w;

   always_comb begin
      memif_rd_w = `WORD_ZERO;
      memif_rd_w[`DIV_ON_BIT] = memif_cfg_r.on;
      memif_rd_w[`RATIO_MSB:0] = memif_cfg_r.ratio;
      second_rd_w = `WORD_ZERO;
      second_rd_w[`DIV_ON_BIT] = second_cfg_r.on;
      second_rd_w[`RATIO_MSB:0] = second_cfg_r.ratio;
      chg_rd_w = `WORD_ZERO;
      chg_rd_w[`MEMIF_FLAG_BIT] = chg_r.memif;
      chg_rd_w[`SECOND_FLAG_BIT] = chg_r.second;
   end

   assign rdata_w =
      hit_cmd ? {31'h0000_0000, cmd_r} :
      hit_stat ? {31'h0000_0000, busy_r} :
      hit_chg ? chg_rd_w :
      hit_memif ? memif_rd_w :
      hit_second ? second_rd_w : `WORD_ZERO;

   // Bus answer: one wait state, then ready for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= `WORD_ZERO;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup_w;
         // Data held through the ready cycle
         if (setup_w) begin
            prdata_r <= pwrite ? `WORD_ZERO : rdata_w;
            pslverr_r <= !hit_any;
         end else if (acc_w) begin
            prdata_r <= `WORD_ZERO;
            pslverr_r <= 1'b0;
         end
      end
   end

   // Divider registers; only on and ratio bits are stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memif_cfg_r.on <= `ON_RST;
         memif_cfg_r.ratio <= `RATIO_RST;
         second_cfg_r.on <= `ON_RST;
         second_cfg_r.ratio <= `RATIO_RST;
      end else begin
         if (wr_memif) begin
            memif_cfg_r.on <= pwdata[`DIV_ON_BIT];
            memif_cfg_r.ratio <= pwdata[`RATIO_MSB:0];
         end
         if (wr_second) begin
            second_cfg_r.on <= pwdata[`DIV_ON_BIT];
            second_cfg_r.ratio <= pwdata[`RATIO_MSB:0];
         end
      end
   end

   // Trigger bit: 1 sets, 0 clears, nothing else moves it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= 1'b0;
      end else if (wr_cmd) begin
         cmd_r <= pwdata[`GO_BIT];
      end
   end

   // Change flags: a new write wins over the clear at the end
   always_comb begin
      chg_nxt = chg_r;
      if (state_r == st_done) begin
         chg_nxt = chg_r & ~applied_r;
      end
      if (set_memif) begin
         chg_nxt.memif = 1'b1;
      end
      if (set_second) begin
         chg_nxt.second = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chg_r <= '0;
      end else begin
         chg_r <= chg_nxt;
      end
   end

   // Change engine state decode
   logic memif_end_w; // Memif divider at a period boundary
   logic second_end_w;
   logic boundary_w; // Safe instant to switch ratios
   logic align_w; // Restart both dividers together

   // Switch on a memif period boundary so no short pulse is cut
   assign boundary_w = memif_end_w || !memif_cfg_r.on;
   assign align_w = (state_r == st_apply);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         // Launch only when no change is running
         st_idle: if (go_start) begin
            state_nxt = st_wait;
         end
         // Hold until the running period ends
         st_wait: if (boundary_w) begin
            state_nxt = st_apply;
         end
         st_apply: state_nxt = st_done;
         st_done: state_nxt = st_idle;
      endcase
   end

   // Sequencer, busy bit and ratio hand-over
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_idle;
         busy_r <= 1'b0;
         applied_r <= '0;
         memif_act_r <= `RATIO_RST;
         second_act_r <= `RATIO_RST;
      end else begin
         state_r <= state_nxt;
         if (state_r == st_idle && go_start) begin
            busy_r <= 1'b1;
         end else if (state_r == st_done) begin
            busy_r <= 1'b0;
         end
         if (state_r == st_apply) begin
            // Only flagged dividers take their new ratio
            applied_r <= chg_r;
            if (chg_r.memif) begin
               memif_act_r <= memif_cfg_r.ratio;
            end
            if (chg_r.second) begin
               second_act_r <= second_cfg_r.ratio;
            end
         end
      end
   end

   // Divisors; reserved codes fold onto the low three bits
   logic [4:0] memif_div_w;
   logic [4:0] second_div_w;

   assign memif_div_w =
      {({1'b0, memif_act_r[`CODE_MSB:0]} + 4'h1), 1'b0};
   assign second_div_w =
      {1'b0, ({1'b0, second_act_r[`CODE_MSB:0]} + 4'h1)};

   // Memif divider; its enable is assumed never cleared by software
   clock_tick_divider memif_div_u (
      .pclk(pclk),
      .presetn(presetn),
      .on(memif_cfg_r.on),
      .divisor(memif_div_w),
      .restart(align_w),
      .tick_r(memif_system_clock),
      .period_end(memif_end_w)
   );

   // Second divider, restarted with the memif one for alignment
   clock_tick_divider second_div_u (
      .pclk(pclk),
      .presetn(presetn),
      .on(second_cfg_r.on),
      .divisor(second_div_w),
      .restart(align_w),
      .tick_r(second_system_clock),
      .period_end(second_end_w)
   );

   // Longest busy span after a launch, in clock cycles
   localparam int go_max_cycles = `GO_MAX_CYCLES;

   // Launch raises busy on the next edge
   a_go_sets_busy: assert property (
      (go_start && state_r == st_idle) |=> busy_r)
      else $error("go did not raise busy");

   // Writing zero starts nothing
   a_zero_no_go: assert property (
      (wr_cmd && !pwdata[`GO_BIT] && state_r == st_idle) |=> !busy_r)
      else $error("write of zero launched change");

   // Trigger bit holds unless software writes zero
   a_cmd_sticky: assert property (
      (cmd_r && !(wr_cmd && !pwdata[`GO_BIT])) |=> cmd_r)
      else $error("trigger bit dropped");

   // Status read returns the busy bit
   a_status_read: assert property (
      (setup_w && !pwrite && hit_stat) |=>
      (prdata_r == {31'h0000_0000, $past(busy_r)}))
      else $error("status read wrong");

   // Reserved read bits stay zero
   a_reserved_zero: assert property (
      pready_r |-> (prdata_r[31:16] == 16'h0000 && prdata_r[14:5] == 10'h000))
      else $error("reserved bits set");

   // A different ratio marks the divider as changed
   a_flag_set: assert property (
      set_memif |=> chg_r.memif)
      else $error("change flag not set");

   // Same for the second divider
   a_flag_second: assert property (
      set_second |=> chg_r.second)
      else $error("second change flag not set");

   // Apply copies the flagged ratio into use
   a_apply_ratio: assert property (
      (align_w && chg_r.second) |=>
      (second_act_r == $past(second_cfg_r.ratio)))
      else $error("ratio not applied");

   // Alignment restarts every enabled output in the same cycle
   a_align_ticks: assert property (
      align_w |=> (memif_system_clock == $past(memif_cfg_r.on)
      && second_system_clock == $past(second_cfg_r.on)))
      else $error("clocks not aligned");

   // Applied flags are cleared unless rewritten the same cycle
   a_done_clear: assert property (
      (state_r == st_done && !set_memif && applied_r.memif) |=> !chg_r.memif)
      else $error("flag not cleared");

   // A change ends within the longest period plus sequencing
   a_go_bounded: assert property (
      (go_start && state_r == st_idle) |=>
      ##[1:go_max_cycles] !busy_r)
      else $error("change never finished");

   // Main scenarios
   c_go_done: cover property (busy_r ##1 !busy_r);
   c_both_flags: cover property (align_w && chg_r.memif && chg_r.second);
   c_second_off: cover property (!second_cfg_r.on && memif_system_clock);
   c_bad_addr: cover property (pready_r && pslverr_r);
   c_both_end: cover property (memif_end_w && second_end_w);

endmodule

`default_nettype wire

// file: sysclk_divider_go_control_tb.sv
// Self-checking testbench for the system clock divider block
`timescale 1ns/1ns
`default_nettype none
`include "sysclk_div_map.svh"

module sysclk_divider_go_control_tb
   import sysclk_div_pkg::*;
;
   // Clock and reset
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   // APB master side
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   // Divided clock ticks
   logic memif_system_clock;
   logic second_system_clock;
   // Bookkeeping
   int n_mismatch = 0;
   int compares = 0;
   int busy_seen = 0;

   // Device under test
   sysclk_divider_go_control sysclk_divider_go_control_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
      .memif_system_clock(memif_system_clock),
      .second_system_clock(second_system_clock)
   );

   // 50 MHz clock
   always #10 pclk = ~pclk;

   // Single comparison point
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One APB transfer; holds the request until pready, only the
   // watchdog ends a wait that never gets an answer
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rdat,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready_r !== 1'b1);
      rdat = prdata_r;
      err = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register write and read wrappers
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0000_0000, d, e);
   endtask

   // Read and compare in one call
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
                      input string msg);
      logic [31:0] d;
      rd(a, d);
      check(d, exp, msg);
   endtask

   // Confirm idle, launch a change and poll status until idle, bounded
   task automatic go_wait();
      logic [31:0] d;
      int n;
      n = 0;
      rdc(`STAT_OFS, 32'h0000_0000, "busy before launch");
      wr(`CMD_OFS, 32'h0000_0001);
      do begin
         rd(`STAT_OFS, d);
         if (d[0] === 1'b1) busy_seen++;
         n++;
      end while (d[0] !== 1'b0 && n < 40);
      check(d, 32'h0000_0000, "status never idle");
   endtask

   // Cycles between two ticks of one divider, sampled mid-cycle
   task automatic measure(input logic sel, output logic [31:0] per);
      int n;
      n = 0;
      @(negedge pclk);
      while ((sel ? second_system_clock : memif_system_clock) !== 1'b1
             && n < 100) begin
         @(negedge pclk);
         n++;
      end
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while ((sel ? second_system_clock : memif_system_clock) !== 1'b1
                 && n < 100);
      per = 32'(n);
   endtask

   // Watchdog, well beyond the expected run of about a thousand cycles
   initial begin
      #(20 * 20000);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic [31:0] p;
      logic [31:0] d;
      logic e;
      int hi;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and default periods
      rdc(`MEMIF_DIV_OFS, 32'h0000_8003, "memif reset");
      rdc(`SECOND_DIV_OFS, 32'h0000_8003, "second reset");
      rdc(`CMD_OFS, 32'h0000_0000, "cmd reset");
      rdc(`STAT_OFS, 32'h0000_0000, "status reset");
      measure(1'b0, p);
      check(p, 32'h0000_0008, "memif default period");
      measure(1'b1, p);
      check(p, 32'h0000_0004, "second default period");
      $display("test reset done");
      // Every legal code on both dividers; reserved codes never written
      for (int c = 0; c < 8; c++) begin
         // Memif enable bit always kept set
         wr(`MEMIF_DIV_OFS, 32'h0000_8000 | 32'(c));
         wr(`SECOND_DIV_OFS, 32'h0000_8000 | 32'(c));
         rdc(`CHG_OFS, 32'h0000_0018, "flags set");
         go_wait();
         rdc(`CHG_OFS, 32'h0000_0000, "flags cleared");
         measure(1'b0, p);
         // Second period divides the memif one, so ticks coincide
         e = second_system_clock;
         check(p, 32'(2 * (c + 1)), "memif period");
         check({31'h0, e}, 32'h0000_0001, "ticks aligned");
         measure(1'b1, p);
         check(p, 32'(c + 1), "second period");
      end
      check(32'(busy_seen > 0), 32'h0000_0001, "busy seen");
      $display("test ratios done");
      // Bit stays set; a further write of 1 launches again
      rdc(`CMD_OFS, 32'h0000_0001, "cmd stays set");
      wr(`SECOND_DIV_OFS, 32'h0000_8002);
      go_wait();
      measure(1'b1, p);
      check(p, 32'h0000_0003, "relaunch applied");
      // Writing 0 clears and starts nothing
      wr(`SECOND_DIV_OFS, 32'h0000_8005);
      wr(`CMD_OFS, 32'hFFFF_FFFE);
      rdc(`CMD_OFS, 32'h0000_0000, "cmd cleared");
      rdc(`STAT_OFS, 32'h0000_0000, "no change started");
      rdc(`CHG_OFS, 32'h0000_0010, "flag still pending");
      measure(1'b1, p);
      check(p, 32'h0000_0003, "old ratio kept");
      go_wait();
      measure(1'b1, p);
      check(p, 32'h0000_0006, "pending ratio applied");
      $display("test command done");
      // Enable gates the second divider; the tick register may still
      // carry a last pulse from the write edge, so let one edge pass
      wr(`SECOND_DIV_OFS, 32'h0000_0005);
      @(posedge pclk);
      hi = 0;
      repeat (20) begin
         @(negedge pclk);
         if (second_system_clock !== 1'b0) hi++;
      end
      check(32'(hi), 32'h0000_0000, "disabled divider ticks");
      rdc(`CHG_OFS, 32'h0000_0000, "same ratio no flag");
      wr(`SECOND_DIV_OFS, 32'h0000_8005);
      measure(1'b1, p);
      check(p, 32'h0000_0006, "re-enabled period");
      $display("test enable done");
      // Reserved bits read zero and ignore writes
      wr(`SECOND_DIV_OFS, 32'hFFFF_FFE5);
      rdc(`SECOND_DIV_OFS, 32'h0000_8005, "divider reserved");
      wr(`STAT_OFS, 32'hFFFF_FFFF);
      rdc(`STAT_OFS, 32'h0000_0000, "status read only");
      // Unmapped address answers with an error and zero data
      apb(1'b0, 32'h029A_0100, 32'h0000_0000, d, e);
      check(d, 32'h0000_0000, "unmapped data");
      check({31'h0, e}, 32'h0000_0001, "unmapped error");
      $display("test reserved done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
